// *** nfu_pkg.sv ***
// nfu_pkg: constants and types of the numeric format unit
package nfu_pkg;
   // pointer and opcode widths
   localparam int NFU_ADDR_W = 20;
   localparam int NFU_OPC_W = 16;
   localparam int NFU_OPC_KEEP = 11;
   // operand image: byte 0 at lowest address
   localparam int NFU_OP_W = 80;
   localparam int NFU_SIGN_BIT = 79;
   localparam int NFU_BCD_W = 72;
   localparam int NFU_BCD_DIGITS = 18;
   // exponent biases
   localparam logic [14:0] NFU_BIAS_S = 15'h007F;
   localparam logic [14:0] NFU_BIAS_L = 15'h03FF;
   localparam logic [14:0] NFU_BIAS_T = 15'h3FFF;
   // temporary real exponent of an integer whose msb is bit 63
   localparam logic [14:0] NFU_INT_EXP = 15'h403E;
   // fraction widths and guard bit positions in a 64-bit significand
   localparam int NFU_FRAC_S = 23;
   localparam int NFU_FRAC_L = 52;
   localparam int NFU_FRAC_T = 63;
   localparam int NFU_GRD_S = NFU_FRAC_T - NFU_FRAC_S - 1;
   localparam int NFU_GRD_L = NFU_FRAC_T - NFU_FRAC_L - 1;
   // sequencing counts
   localparam logic [6:0] NFU_BCD_LAST = 7'h11;
   localparam logic [6:0] NFU_DABBLE_LAST = 7'h3F;
   localparam logic [6:0] NFU_SH_MAX = 7'h7F;

   typedef enum logic [2:0] {
      FMT_WORD_INT = 3'b000,
      FMT_SHORT_INT = 3'b001,
      FMT_LONG_INT = 3'b010,
      FMT_BCD = 3'b011,
      FMT_SHORT_REAL = 3'b100,
      FMT_LONG_REAL = 3'b101,
      FMT_TEMP_REAL = 3'b110
   } nfu_fmt_t;

   typedef enum logic [1:0] {
      RC_NEAREST = 2'b00,
      RC_DOWN = 2'b01,
      RC_UP = 2'b10,
      RC_CHOP = 2'b11
   } nfu_rc_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_BCD_IN = 2'b01,
      ST_CONV = 2'b10,
      ST_BCD_OUT = 2'b11
   } nfu_state_t;
endpackage

// *** nfu_if.sv ***
// nfu_if: carriers between the numeric format unit modules
`timescale 1ns/1ps
interface nfu_norm_if;
   logic [63:0] mag;
   logic [63:0] shifted;
   logic [5:0] lz;
   logic zero;
   modport core (output mag, input shifted, lz, zero);
   modport unit (input mag, output shifted, lz, zero);
endinterface

interface nfu_ptr_if;
   logic capture;
   logic mem_ref;
   logic [nfu_pkg::NFU_ADDR_W-1:0] instr_addr;
   logic [nfu_pkg::NFU_ADDR_W-1:0] operand_addr;
   logic [nfu_pkg::NFU_OPC_W-1:0] opcode;
   logic [nfu_pkg::NFU_ADDR_W-1:0] saved_instr;
   logic [nfu_pkg::NFU_ADDR_W-1:0] saved_operand;
   logic [nfu_pkg::NFU_OPC_KEEP-1:0] saved_opcode;
   modport core (output capture, mem_ref, instr_addr, operand_addr, opcode,
      input saved_instr, saved_operand, saved_opcode);
   modport keeper (input capture, mem_ref, instr_addr, operand_addr, opcode,
      output saved_instr, saved_operand, saved_opcode);
endinterface

// *** nfu_norm.sv ***
// nfu_norm: leading-zero count and left alignment of a magnitude
`timescale 1ns/1ps
module nfu_norm (
   // magnitude in, aligned significand out
   nfu_norm_if.unit n
);
   import nfu_pkg::*;

   // highest set bit wins, so the ascending loop keeps the last hit
   always_comb begin
      n.lz = '0;
      for (int i = 0; i < 64; i++) begin
         if (n.mag[i]) begin
            n.lz = 6'(NFU_FRAC_T - i);
         end
      end
      n.zero = (n.mag == '0);
      n.shifted = n.mag << n.lz; // integer bit lands in bit 63
   end
endmodule

// *** nfu_excptr.sv ***
// nfu_excptr: exception pointer capture for each executed instruction
`timescale 1ns/1ps
module nfu_excptr #(
   parameter int ADDR_W = nfu_pkg::NFU_ADDR_W
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // capture group
   nfu_ptr_if.keeper p
);
   import nfu_pkg::*;

   logic [NFU_ADDR_W-1:0] next_instr;
   logic [NFU_ADDR_W-1:0] next_operand;
   logic [NFU_OPC_KEEP-1:0] next_opcode;
   logic [NFU_OPC_KEEP-1:0] opc_low;

   // carrier widths are fixed, so only the documented width is served
   if (ADDR_W != NFU_ADDR_W) begin : g_width_check
      $error("exception pointer width must be 20 bits");
   end

   assign opc_low = p.opcode[NFU_OPC_KEEP-1:0];

   // upper opcode bits are always the escape hook, not worth storing
   always_comb begin
      next_instr = p.saved_instr;
      next_operand = p.saved_operand;
      next_opcode = p.saved_opcode;
      if (p.capture) begin
         next_instr = p.instr_addr;
         next_opcode = opc_low;
         if (p.mem_ref) begin
            next_operand = p.operand_addr;
         end
      end
   end

   // pointer registers
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         p.saved_instr <= '0;
         p.saved_operand <= '0;
         p.saved_opcode <= '0;
      end else begin
         p.saved_instr <= next_instr;
         p.saved_operand <= next_operand;
         p.saved_opcode <= next_opcode;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   property p_instr_addr;
      p.capture |=> p.saved_instr == $past(p.instr_addr);
   endproperty
   a_instr_addr: assert property (p_instr_addr)
      else $error("instruction address not captured whole");

   property p_opcode_low;
      p.capture |=> p.saved_opcode == $past(opc_low);
   endproperty
   a_opcode_low: assert property (p_opcode_low)
      else $error("opcode low bits not captured");

   property p_operand_kept;
      p.capture && !p.mem_ref |=> $stable(p.saved_operand);
   endproperty
   a_operand_kept: assert property (p_operand_kept)
      else $error("operand address changed without memory reference");
endmodule

// *** nfu_top.sv ***
// nfu_top: operand format conversion to and from temporary real
`timescale 1ns/1ps
module nfu_top (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // conversion request
   input wire logic req_valid,
   input wire logic req_store,
   input wire nfu_pkg::nfu_fmt_t req_fmt,
   input wire nfu_pkg::nfu_rc_t rounding_control_field,
   input wire logic [nfu_pkg::NFU_OP_W-1:0] req_mem_data,
   input wire logic [nfu_pkg::NFU_OP_W-1:0] req_treal,
   // instruction context
   input wire logic req_mem_ref,
   input wire logic [nfu_pkg::NFU_ADDR_W-1:0] req_instr_addr,
   input wire logic [nfu_pkg::NFU_OPC_W-1:0] req_opcode,
   input wire logic [nfu_pkg::NFU_ADDR_W-1:0] req_operand_addr,
   // conversion answer
   output logic busy,
   output logic done,
   output logic res_inexact,
   output logic [nfu_pkg::NFU_OP_W-1:0] res_treal,
   output logic [nfu_pkg::NFU_OP_W-1:0] res_mem_data,
   // exception pointers
   output logic [nfu_pkg::NFU_ADDR_W-1:0] excp_instr_addr,
   output logic [nfu_pkg::NFU_OPC_KEEP-1:0] excp_opcode,
   output logic [nfu_pkg::NFU_ADDR_W-1:0] excp_operand_addr
);
   import nfu_pkg::*;

   nfu_state_t state, next_state;
   nfu_fmt_t fmt_q, next_fmt;
   nfu_rc_t rc_q, next_rc;
   logic op_q, next_op;
   logic [NFU_OP_W-1:0] data_q, next_data;
   logic [NFU_OP_W-1:0] treal_q, next_treal_q;
   logic [6:0] cnt, next_cnt;
   logic [63:0] acc, next_acc;
   logic [NFU_BCD_W-1:0] bcd, next_bcd;
   logic next_busy, next_done, next_inexact;
   logic [NFU_OP_W-1:0] next_res_treal, next_res_mem;
   logic taken;
   logic [3:0] digit;
   logic [NFU_BCD_W-1:0] dab_full, dab_shift;

   // conversion datapath
   logic [63:0] ival, imag_r, ival_r;
   logic isign, s_t, inc_i, inc_s, inc_l, grd_i, stk_i;
   logic [14:0] e_t, e_s, e_l, e_diff;
   logic [63:0] m_t;
   logic [6:0] sh;
   logic [127:0] ext;
   logic [24:0] sum_s;
   logic [53:0] sum_l;
   logic [NFU_OP_W-1:0] conv_treal, conv_mem;
   logic conv_inexact;

   nfu_norm_if norm ();
   nfu_ptr_if ptr ();

   // rounding increment from lsb, guard and sticky bits
   function automatic logic rnd_up(input nfu_rc_t rc, input logic sign,
         input logic lsb, input logic grd, input logic stk);
      logic up;
      unique case (rc)
         RC_NEAREST: up = grd & (stk | lsb); // ties go to even
         RC_DOWN: up = sign & (grd | stk);
         RC_UP: up = ~sign & (grd | stk);
         RC_CHOP: up = 1'b0;
      endcase
      return up;
   endfunction

   // one double-dabble correction over all decimal digits
   function automatic logic [NFU_BCD_W-1:0] dabble(
         input logic [NFU_BCD_W-1:0] d);
      logic [NFU_BCD_W-1:0] r;
      r = d;
      for (int i = 0; i < NFU_BCD_DIGITS; i++) begin
         if (r[i*4 +: 4] > 4'h4) begin
            r[i*4 +: 4] = r[i*4 +: 4] + 4'h3;
         end
      end
      return r;
   endfunction

   nfu_norm u_norm (
      .n(norm.unit)
   );

   nfu_excptr #(
      .ADDR_W(NFU_ADDR_W)
   ) u_excptr (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .p(ptr.keeper)
   );

   // every executed instruction refreshes the instruction and opcode pointers; the operand pointer only on memory references
   assign taken = (state == ST_IDLE) && req_valid;
   assign ptr.capture = taken;
   assign ptr.mem_ref = req_mem_ref;
   assign ptr.instr_addr = req_instr_addr;
   assign ptr.operand_addr = req_operand_addr;
   assign ptr.opcode = req_opcode;
   assign excp_instr_addr = ptr.saved_instr;
   assign excp_opcode = ptr.saved_opcode;
   assign excp_operand_addr = ptr.saved_operand;

   // most significant digit is taken first; nibbles assumed 0..9
   assign digit = data_q[{cnt[4:0], 2'b00} +: 4];
   assign dab_full = dabble(bcd);
   assign dab_shift = {dab_full[NFU_BCD_W-2:0], acc[63]};

   // format conversion, both directions
   always_comb begin
      s_t = treal_q[NFU_SIGN_BIT];
      e_t = treal_q[78:64];
      m_t = treal_q[63:0];
      // load: sign-extend the integer image, low byte at low address
      unique case (fmt_q)
         FMT_WORD_INT: ival = {{48{data_q[15]}}, data_q[15:0]};
         FMT_SHORT_INT: ival = {{32{data_q[31]}}, data_q[31:0]};
         default: ival = data_q[63:0];
      endcase
      isign = (fmt_q == FMT_BCD) ? data_q[NFU_SIGN_BIT] : ival[63];
      norm.mag = (fmt_q == FMT_BCD) ? acc : (ival[63] ? -ival : ival);
      // store: align significand so bit 64 of ext is the integer lsb
      e_diff = NFU_INT_EXP - e_t;
      if (e_t > NFU_INT_EXP) begin
         sh = '0; // out of range, shift forced to zero; overflow is not detected
      end else if (e_diff > {8'h00, NFU_SH_MAX}) begin
         sh = NFU_SH_MAX;
      end else begin
         sh = e_diff[6:0];
      end
      ext = {m_t, 64'h0} >> sh;
      grd_i = ext[63];
      stk_i = |ext[62:0];
      inc_i = rnd_up(rc_q, s_t, ext[64], grd_i, stk_i);
      imag_r = ext[127:64] + {63'h0, inc_i};
      ival_r = s_t ? -imag_r : imag_r;
      // short real: keep 24 significand bits, carry bumps the exponent
      inc_s = rnd_up(rc_q, s_t, m_t[NFU_GRD_S+1], m_t[NFU_GRD_S],
         |m_t[NFU_GRD_S-1:0]);
      sum_s = {1'b0, m_t[63:NFU_GRD_S+1]} + {24'h0, inc_s};
      e_s = e_t - NFU_BIAS_T + NFU_BIAS_S + {14'h0, sum_s[24]};
      // long real: keep 53 significand bits
      inc_l = rnd_up(rc_q, s_t, m_t[NFU_GRD_L+1], m_t[NFU_GRD_L],
         |m_t[NFU_GRD_L-1:0]);
      sum_l = {1'b0, m_t[63:NFU_GRD_L+1]} + {53'h0, inc_l};
      e_l = e_t - NFU_BIAS_T + NFU_BIAS_L + {14'h0, sum_l[53]};
      conv_treal = '0;
      conv_mem = '0;
      conv_inexact = 1'b0;
      if (!op_q) begin
         // loads widen exactly into temporary real
         unique case (fmt_q)
            FMT_SHORT_REAL: begin
               if (data_q[30:0] == '0) begin
                  conv_treal = {data_q[31], 79'h0};
               end else begin
                  conv_treal = {data_q[31],
                     {7'h0, data_q[30:23]} - NFU_BIAS_S + NFU_BIAS_T,
                     1'b1, data_q[22:0], 40'h0};
               end
            end
            FMT_LONG_REAL: begin
               if (data_q[62:0] == '0) begin
                  conv_treal = {data_q[63], 79'h0};
               end else begin
                  conv_treal = {data_q[63],
                     {4'h0, data_q[62:52]} - NFU_BIAS_L + NFU_BIAS_T,
                     1'b1, data_q[51:0], 11'h0};
               end
            end
            FMT_TEMP_REAL: conv_treal = data_q;
            default: begin
               // integers of 64 bits fit the significand: exact
               if (norm.zero) begin
                  conv_treal = {isign & (fmt_q == FMT_BCD), 79'h0};
               end else begin
                  conv_treal = {isign, NFU_INT_EXP - {9'h0, norm.lz},
                     norm.shifted};
               end
            end
         endcase
      end else begin
         // stores narrow with rounding; sign ends in the top byte
         unique case (fmt_q)
            FMT_WORD_INT: conv_mem = {64'h0, ival_r[15:0]};
            FMT_SHORT_INT: conv_mem = {48'h0, ival_r[31:0]};
            FMT_LONG_INT: conv_mem = {16'h0, ival_r};
            FMT_SHORT_REAL: begin
               if (m_t == '0) begin
                  conv_mem = {48'h0, s_t, 31'h0};
               end else begin
                  conv_mem = {48'h0, s_t, e_s[7:0],
                     sum_s[NFU_FRAC_S-1:0]};
               end
            end
            FMT_LONG_REAL: begin
               if (m_t == '0) begin
                  conv_mem = {16'h0, s_t, 63'h0};
               end else begin
                  conv_mem = {16'h0, s_t, e_l[10:0],
                     sum_l[NFU_FRAC_L-1:0]};
               end
            end
            FMT_TEMP_REAL: conv_mem = treal_q;
            default: conv_mem = '0; // decimal result built later
         endcase
         unique case (fmt_q)
            FMT_SHORT_REAL: conv_inexact = m_t[NFU_GRD_S] |
               (|m_t[NFU_GRD_S-1:0]);
            FMT_LONG_REAL: conv_inexact = m_t[NFU_GRD_L] |
               (|m_t[NFU_GRD_L-1:0]);
            FMT_TEMP_REAL: conv_inexact = 1'b0;
            default: conv_inexact = grd_i | stk_i;
         endcase
      end
   end

   // sequencer: one-cycle formats, 18 digit steps in, 64 shifts out
   always_comb begin
      next_state = state;
      next_op = op_q;
      next_fmt = fmt_q;
      next_rc = rc_q;
      next_data = data_q;
      next_treal_q = treal_q;
      next_cnt = cnt;
      next_acc = acc;
      next_bcd = bcd;
      next_busy = busy;
      next_done = 1'b0;
      next_inexact = res_inexact;
      next_res_treal = res_treal;
      next_res_mem = res_mem_data;
      unique case (state)
         ST_IDLE: begin
            if (req_valid) begin
               next_op = req_store;
               next_fmt = req_fmt;
               next_rc = rounding_control_field;
               next_data = req_mem_data;
               next_treal_q = req_treal;
               next_busy = 1'b1;
               next_acc = '0;
               next_cnt = NFU_BCD_LAST;
               next_state = (!req_store && req_fmt == FMT_BCD) ?
                  ST_BCD_IN : ST_CONV;
            end
         end
         ST_BCD_IN: begin
            next_acc = (acc << 3) + (acc << 1) + {60'h0, digit};
            next_cnt = cnt - 7'h01;
            if (cnt == '0) begin
               next_state = ST_CONV;
            end
         end
         ST_CONV: begin
            next_inexact = conv_inexact;
            if (op_q && fmt_q == FMT_BCD) begin
               next_acc = imag_r; // magnitude only, never complemented
               next_bcd = '0;
               next_cnt = '0;
               next_state = ST_BCD_OUT;
            end else begin
               if (op_q) begin
                  next_res_mem = conv_mem;
               end else begin
                  next_res_treal = conv_treal;
               end
               next_done = 1'b1;
               next_busy = 1'b0;
               next_state = ST_IDLE;
            end
         end
         ST_BCD_OUT: begin
            next_bcd = dab_shift;
            next_acc = acc << 1;
            next_cnt = cnt + 7'h01;
            if (cnt == NFU_DABBLE_LAST) begin
               next_res_mem = {s_t, 7'h0, dab_shift};
               next_done = 1'b1;
               next_busy = 1'b0;
               next_state = ST_IDLE;
            end
         end
      endcase
   end

   // state and answer registers
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         op_q <= 1'b0;
         fmt_q <= FMT_WORD_INT;
         rc_q <= RC_NEAREST;
         data_q <= '0;
         treal_q <= '0;
         cnt <= '0;
         acc <= '0;
         bcd <= '0;
         busy <= 1'b0;
         done <= 1'b0;
         res_inexact <= 1'b0;
         res_treal <= '0;
         res_mem_data <= '0;
      end else begin
         state <= next_state;
         op_q <= next_op;
         fmt_q <= next_fmt;
         rc_q <= next_rc;
         data_q <= next_data;
         treal_q <= next_treal_q;
         cnt <= next_cnt;
         acc <= next_acc;
         bcd <= next_bcd;
         busy <= next_busy;
         done <= next_done;
         res_inexact <= next_inexact;
         res_treal <= next_res_treal;
         res_mem_data <= next_res_mem;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   property p_done_bound;
      taken |-> ##[2:66] done;
   endproperty
   a_done_bound: assert property (p_done_bound)
      else $error("conversion did not finish in time");

   property p_int_zero;
      done && !op_q && fmt_q != FMT_BCD && fmt_q < FMT_SHORT_REAL &&
         res_treal[63:0] == '0 |-> res_treal == '0;
   endproperty
   a_int_zero: assert property (p_int_zero)
      else $error("binary integer zero not positive");

   property p_norm;
      done && !op_q && fmt_q != FMT_TEMP_REAL && res_treal[78:64] != '0
         |-> res_treal[63];
   endproperty
   a_norm: assert property (p_norm)
      else $error("loaded value not normalized");

   property p_bias_short;
      state == ST_CONV && !op_q && fmt_q == FMT_SHORT_REAL &&
         data_q[30:23] != '0 |=> res_treal[78:64] ==
         {7'h0, data_q[30:23]} - NFU_BIAS_S + NFU_BIAS_T;
   endproperty
   a_bias_short: assert property (p_bias_short)
      else $error("short real exponent rebias wrong");

   property p_chop;
      state == ST_CONV && rc_q == RC_CHOP |-> !inc_i && !inc_s && !inc_l;
   endproperty
   a_chop: assert property (p_chop)
      else $error("chop mode incremented a result");

   property p_bcd_sign;
      done && op_q && fmt_q == FMT_BCD |->
         res_mem_data[78:72] == '0 && res_mem_data[79] == treal_q[79];
   endproperty
   a_bcd_sign: assert property (p_bcd_sign)
      else $error("decimal sign byte wrong");
endmodule

// *** nfu_host_model.sv ***
// nfu_host_model: host side that issues conversion requests
`timescale 1ns/1ps
module nfu_host_model (
   // clock and block state
   input wire logic sys_clk,
   input wire logic busy,
   // request
   output logic req_valid,
   output logic req_store,
   output nfu_pkg::nfu_fmt_t req_fmt,
   output nfu_pkg::nfu_rc_t rounding_control_field,
   output logic [79:0] req_mem_data,
   output logic [79:0] req_treal,
   output logic req_mem_ref,
   output logic [19:0] req_instr_addr,
   output logic [15:0] req_opcode,
   output logic [19:0] req_operand_addr
);
   import nfu_pkg::*;
   // quiet bus at time zero
   initial begin
      req_valid = 1'b0;
      req_store = 1'b0;
      req_fmt = FMT_WORD_INT;
      rounding_control_field = RC_NEAREST;
      req_mem_data = 80'h0;
      req_treal = 80'h0;
      req_mem_ref = 1'b0;
      req_instr_addr = 20'h0;
      req_opcode = 16'h0;
      req_operand_addr = 20'h0;
   end
   // held until an idle edge takes it; valid stays up so that a
   // following request never assigns the strobe twice in one step
   task automatic issue(input logic st, input nfu_fmt_t f,
         input nfu_rc_t rc, input logic [79:0] md, input logic [79:0] tr,
         input logic mr, input logic [19:0] ia, input logic [15:0] op,
         input logic [19:0] oa);
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req_store <= st;
      req_fmt <= f;
      rounding_control_field <= rc;
      req_mem_data <= md;
      req_treal <= tr;
      req_mem_ref <= mr;
      req_instr_addr <= ia;
      req_opcode <= op;
      req_operand_addr <= oa;
      @(posedge sys_clk);
      while (busy !== 1'b0) @(posedge sys_clk);
   endtask
   // called at the take edge: a held strobe would be taken again
   // as soon as the block goes idle, with no note behind it
   task automatic release_req();
      req_valid <= 1'b0;
   endtask
endmodule

// *** numeric_format_unit_tb.sv ***
// numeric_format_unit_tb: self-checking bench of the format unit
`timescale 1ns/1ps
module numeric_format_unit_tb;
   import nfu_pkg::*;
   typedef struct {logic [79:0] val; logic inx; logic [19:0] ia;
      logic [10:0] op; logic [19:0] oa; logic st;} nfu_note_t;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic busy, done, res_inexact, req_valid, req_store, req_mem_ref;
   nfu_fmt_t req_fmt;
   nfu_rc_t rounding_control_field;
   logic [79:0] res_treal, res_mem_data, req_mem_data, req_treal;
   logic [19:0] excp_instr_addr, excp_operand_addr, req_instr_addr;
   logic [19:0] req_operand_addr, last_oa;
   logic [15:0] req_opcode;
   logic [10:0] excp_opcode;
   nfu_note_t q[$];
   nfu_note_t n;
   int fails = 0;
   int cmp_count = 0;
   int seed = 44908;

   always #4 sys_clk = ~sys_clk;

   nfu_top u_nfu_top (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .req_valid(req_valid), .req_store(req_store), .req_fmt(req_fmt),
      .rounding_control_field(rounding_control_field),
      .req_mem_data(req_mem_data), .req_treal(req_treal),
      .req_mem_ref(req_mem_ref), .req_instr_addr(req_instr_addr),
      .req_opcode(req_opcode), .req_operand_addr(req_operand_addr),
      .busy(busy), .done(done), .res_inexact(res_inexact),
      .res_treal(res_treal), .res_mem_data(res_mem_data),
      .excp_instr_addr(excp_instr_addr), .excp_opcode(excp_opcode),
      .excp_operand_addr(excp_operand_addr));
   nfu_host_model u_nfu_host_model (.sys_clk(sys_clk), .busy(busy),
      .req_valid(req_valid), .req_store(req_store), .req_fmt(req_fmt),
      .rounding_control_field(rounding_control_field),
      .req_mem_data(req_mem_data), .req_treal(req_treal),
      .req_mem_ref(req_mem_ref), .req_instr_addr(req_instr_addr),
      .req_opcode(req_opcode), .req_operand_addr(req_operand_addr));

   task automatic check(input logic [79:0] seen, input logic [79:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // integer value to temporary real, worked out bit by bit
   function automatic logic [79:0] int2t(input logic [63:0] v);
      logic [63:0] m;
      logic [14:0] e;
      m = v[63] ? -v : v;
      e = NFU_INT_EXP;
      if (m == 64'h0) return 80'h0;
      while (m[63] !== 1'b1) begin
         m = m << 1;
         e = e - 15'h0001;
      end
      return {v[63], e, m};
   endfunction

   // random context; operand pointer only moves on memory references
   task automatic send(input logic st, input int f, input int rc,
         input logic [79:0] md, input logic [79:0] tr,
         input logic [79:0] ev, input logic inx);
      logic mr;
      logic [19:0] ia, oa;
      logic [15:0] op;
      mr = 1'($random(seed));
      ia = 20'($random(seed));
      oa = 20'($random(seed));
      op = {5'h1B, 11'($random(seed))};
      u_nfu_host_model.issue(st, nfu_fmt_t'(f), nfu_rc_t'(rc), md, tr,
         mr, ia, op, oa);
      if (mr) last_oa = oa;
      q.push_back('{ev, inx, ia, op[10:0], last_oa, st});
   endtask

   task automatic end_test(input string name);
      u_nfu_host_model.release_req();
      for (int c = 0; c < 200 && q.size() != 0; c++) @(posedge sys_clk);
      check(80'(q.size()), 80'h0);
      $display("test %s ended", name);
   endtask

   // results appear in order; each done retires the oldest note
   always @(posedge sys_clk) begin
      if (done === 1'b1) begin
         if (q.size() == 0) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, 1'b1, 1'b0);
         end else begin
            n = q.pop_front();
            if (n.st) check(res_mem_data, n.val);
            else check(res_treal, n.val);
            check(res_inexact, n.inx);
            check(excp_instr_addr, n.ia);
            check(excp_opcode, n.op);
            check(excp_operand_addr, n.oa);
            check(busy, 1'b0);
         end
      end
   end

   initial begin
      #300000;
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
      finish_test();
   end

   initial begin
      logic [63:0] r, v, val;
      logic [79:0] img, tr;
      logic [71:0] dg;
      logic [22:0] k;
      logic [14:0] e;
      logic [7:0] e8;
      logic [10:0] e11;
      logic s, g, st, up;
      last_oa = 20'h0;
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      // integers of every width, back to back, first value zero
      for (int f = 0; f < 3; f++) begin
         for (int i = 0; i < 6; i++) begin
            r = {32'($random(seed)), 32'($random(seed))};
            v = (i == 0) ? 64'h0 : (f == 0) ? {{48{r[15]}}, r[15:0]} :
               (f == 1) ? {{32{r[31]}}, r[31:0]} : r;
            img = (f == 0) ? {64'h0, v[15:0]} :
               (f == 1) ? {48'h0, v[31:0]} : {16'h0, v};
            send(1'b0, f, 0, img, 80'h0, int2t(v), 1'b0);
            send(1'b1, f, i % 4, 80'h0, int2t(v), img, 1'b0);
         end
      end
      end_test("integers");
      // real loads plus long and temporary real stores, exponents kept clear of the special codes
      for (int i = 0; i < 6; i++) begin
         r = {32'($random(seed)), 32'($random(seed))};
         e8 = {r[8], r[6:1], ~r[8]};
         e11 = {r[62], r[61:53], ~r[62]};
         img = {48'h0, r[63], e8, r[30:8]};
         tr = {r[63], 15'(e8) + 15'h3F80, 1'b1, r[30:8], 40'h0};
         send(1'b0, 4, 0, img, 80'h0, tr, 1'b0);
         img = {16'h0, r[63], e11, r[51:0]};
         tr = {r[63], 15'(e11) + 15'h3C00, 1'b1, r[51:0], 11'h0};
         send(1'b0, 5, 0, img, 80'h0, tr, 1'b0);
         send(1'b1, 5, 0, 80'h0, tr, img, 1'b0);
         img = {r[63], 2'b01, r[60:48], 1'b1, r[47:0], 15'(r)};
         send(1'b0, 6, 0, img, 80'h0, img, 1'b0);
         send(1'b1, 6, 0, 80'h0, img, img, 1'b0);
      end
      end_test("real loads");
      // short real stores in every rounding mode, one tie each
      for (int m = 0; m < 4; m++) begin
         for (int i = 0; i < 4; i++) begin
            r = {32'($random(seed)), 32'($random(seed))};
            r[63] = 1'b1;
            r[50] = 1'b0; // no carry out of the fraction
            if (i == 2) r[39:0] = 40'h8000000000;
            s = i[0];
            e = 15'h3FF0 + 15'(r[4:0]);
            g = r[39];
            st = |r[38:0];
            up = (m == 0) ? g & (st | r[40]) : (m == 1) ? s & (g | st) :
               (m == 2) ? ~s & (g | st) : 1'b0;
            k = r[62:40] + 23'(up);
            img = {48'h0, s, 8'(e - 15'h3F80), k};
            send(1'b1, 4, m, 80'h0, {s, e, r}, img, g | st);
         end
      end
      end_test("rounding");
      // decimal round trip, digits kept to zero through nine
      for (int i = 0; i < 4; i++) begin
         val = 64'h0;
         dg = 72'h0;
         for (int d = 0; d < 18; d++) begin
            k = 23'(unsigned'($random(seed)) % 10);
            val = val * 10 + 64'(k);
            dg = {dg[67:0], k[3:0]};
         end
         s = i[0];
         img = {s, 7'h0, dg};
         tr = int2t(s ? -val : val);
         send(1'b0, 3, 0, img, 80'h0, tr, 1'b0);
         send(1'b1, 3, i, 80'h0, tr, img, 1'b0);
      end
      end_test("decimal");
      finish_test();
   end
endmodule
